// ==== src/pmp_pkg.sv ====
// Package with register map, reset values and field constants of the pixel parameter registers.
package pmp_pkg;

  // ==========================================================================
  // Register word indices on the Avalon-MM address (byte address = 4 * index)
  // ==========================================================================
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ALIGN = 4'h1;
  localparam logic [3:0] OFS_NPTR = 4'h2;
  localparam logic [3:0] OFS_FG = 4'h3;
  localparam logic [3:0] OFS_BG = 4'h4;
  localparam logic [3:0] OFS_TC = 4'h5;
  localparam logic [3:0] OFS_WMASK = 4'h6;
  localparam logic [3:0] OFS_TMASK = 4'h7;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int DEPTH_BIT = 0;
  localparam int NIB_W = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic RST_DEPTH = 1'b0;
  localparam logic [1:0] RST_ALIGN = 2'h0;
  localparam logic [1:0] RST_NPTR = 2'h0;
  localparam logic [7:0] RST_FG = 8'hFF;
  localparam logic [7:0] RST_BG = 8'h00;
  localparam logic [7:0] RST_TC = 8'h00;
  localparam logic [7:0] RST_WMASK = 8'hFF;
  localparam logic [7:0] RST_TMASK = 8'hFF;

  // ==========================================================================
  // Avalon-MM response codes
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== src/pmp_regs.sv ====
// Pixel manipulation parameter registers with their source-alignment, colour and mask datapath.
`timescale 1ns/1ps

// What this block does
// - Two-bit alignment amount register picks how far the source word shifts.
// - Alignment always shifts left to right; no right-to-left mode exists.
// - Two-bit nibble pointer selects the source nibble for bit-expand colour.
// - Pack-compare results land in the nibble the nibble pointer selects.
// - Nibble pointer increments after every operation, whatever depth, unless a pointer write lands in the same cycle.
// - Eight-bit foreground colour is written for set pixels in expansion.
// - Eight-bit background colour is written for clear pixels in expansion.
// - At four bits per pixel, colour nibbles alternate over successive pixels.
// - Eight-bit transparent colour is compared against source pixels.
// - At four bits per pixel, transparent nibbles alternate over successive pixels.
// - Eight-bit write mask applies to every destination byte at once.
// - Write mask ones mark destination bits that may change.
// - Eight-bit test mask disables transparency comparison on chosen bits.
// - Test mask zeros drop the matching bit from the transparency compare.
// - Depth control bit one selects eight bits per pixel, zero four.
module pmp_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  input wire logic op_start_i,
  input wire logic [15:0] src_word_i,
  input wire logic [15:0] dst_word_i,
  input wire logic [15:0] result_word_i,
  output logic [15:0] aligned_o,
  output logic [15:0] expand_o,
  output logic [3:0] transp_o,
  output logic [15:0] dest_o,
  output logic [15:0] pack_o,
  output logic [1:0] nptr_o,
  output logic op_done_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic depth8;
    logic [1:0] align;
    logic [1:0] nptr;
    logic [7:0] fg;
    logic [7:0] bg;
    logic [7:0] tc;
    logic [7:0] wm;
    logic [7:0] tm;
    logic wait_rq;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [15:0] prev_src;
    logic [15:0] aligned;
    logic [15:0] expand;
    logic [3:0] transp;
    logic [15:0] dest;
    logic [15:0] pack;
    logic done;
  } pmp_state_s;

  pmp_state_s q_ff;
  pmp_state_s nxt_q;

  logic req;
  logic acc;
  logic wr_acc;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] shift_cat;
  logic [15:0] al_src;
  logic [3:0] sel_nib;
  logic [15:0] exp_w;
  logic [3:0] tr_w;
  logic [15:0] wm16;

  assign req = avs_read_i | avs_write_i;
  // A request completes at the edge where waitrequest is seen low.
  assign acc = req & ~q_ff.wait_rq;
  assign wr_acc = acc & avs_write_i & avs_byteenable_i[0];
  assign mapped = avs_address_i <= pmp_pkg::OFS_TMASK;

  // ==========================================================================
  // Datapath
  // ==========================================================================
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      pmp_pkg::OFS_CTRL: rd_mux[pmp_pkg::DEPTH_BIT] = q_ff.depth8;
      pmp_pkg::OFS_ALIGN: rd_mux[1:0] = q_ff.align;
      pmp_pkg::OFS_NPTR: rd_mux[1:0] = q_ff.nptr;
      pmp_pkg::OFS_FG: rd_mux[7:0] = q_ff.fg;
      pmp_pkg::OFS_BG: rd_mux[7:0] = q_ff.bg;
      pmp_pkg::OFS_TC: rd_mux[7:0] = q_ff.tc;
      pmp_pkg::OFS_WMASK: rd_mux[7:0] = q_ff.wm;
      pmp_pkg::OFS_TMASK: rd_mux[7:0] = q_ff.tm;
      default: rd_mux = 32'h0000_0000;
    endcase

    // Source slides toward the low end by whole nibbles; the previous source word fills from the left.
    shift_cat = {q_ff.prev_src, src_word_i} >> {q_ff.align, 2'h0};
    al_src = shift_cat[15:0];

    sel_nib = src_word_i[q_ff.nptr * pmp_pkg::NIB_W +: pmp_pkg::NIB_W];
    exp_w = 16'h0000;
    tr_w = 4'h0;
    if (q_ff.depth8)
    begin
      // Two byte pixels per word, pixel 0 in the upper byte.
      for (int k = 0; k < 2; k++)
      begin
        exp_w[15 - 8 * k -: 8] = sel_nib[3 - k] ? q_ff.fg : q_ff.bg;
        tr_w[3 - k] = ((al_src[15 - 8 * k -: 8] ^ q_ff.tc) & q_ff.tm) == 8'h00;
      end
    end
    else
    begin
      // Four nibble pixels; even pixels use the upper colour nibble, odd the lower.
      for (int k = 0; k < 4; k++)
      begin
        if (k % 2 == 0)
        begin
          exp_w[15 - 4 * k -: 4] = sel_nib[3 - k] ? q_ff.fg[7:4] : q_ff.bg[7:4];
          tr_w[3 - k] = ((al_src[15 - 4 * k -: 4] ^ q_ff.tc[7:4]) & q_ff.tm[7:4]) == 4'h0;
        end
        else
        begin
          exp_w[15 - 4 * k -: 4] = sel_nib[3 - k] ? q_ff.fg[3:0] : q_ff.bg[3:0];
          tr_w[3 - k] = ((al_src[15 - 4 * k -: 4] ^ q_ff.tc[3:0]) & q_ff.tm[3:0]) == 4'h0;
        end
      end
    end
    wm16 = {q_ff.wm, q_ff.wm};
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;

    // Waitrequest drops for exactly one cycle per request.
    if (req && q_ff.wait_rq)
    begin
      nxt_q.wait_rq = 1'b0;
      nxt_q.rdata = avs_read_i && mapped ? rd_mux : 32'h0000_0000;
      nxt_q.resp = mapped ? pmp_pkg::RESP_OKAY : pmp_pkg::RESP_SLVERR;
    end
    else
    begin
      nxt_q.wait_rq = 1'b1;
    end

    if (op_start_i)
    begin
      nxt_q.prev_src = src_word_i;
      nxt_q.aligned = al_src;
      nxt_q.expand = exp_w;
      nxt_q.transp = tr_w;
      nxt_q.dest = (result_word_i & wm16) | (dst_word_i & ~wm16);
      nxt_q.pack = dst_word_i;
      nxt_q.pack[q_ff.nptr * pmp_pkg::NIB_W +: pmp_pkg::NIB_W] = tr_w;
      nxt_q.nptr = q_ff.nptr + 2'h1;
      nxt_q.done = 1'b1;
    end

    // A software write beats the automatic advance in the same cycle.
    if (wr_acc)
    begin
      case (avs_address_i)
        pmp_pkg::OFS_CTRL: nxt_q.depth8 = avs_writedata_i[pmp_pkg::DEPTH_BIT];
        pmp_pkg::OFS_ALIGN: nxt_q.align = avs_writedata_i[1:0];
        pmp_pkg::OFS_NPTR: nxt_q.nptr = avs_writedata_i[1:0];
        pmp_pkg::OFS_FG: nxt_q.fg = avs_writedata_i[7:0];
        pmp_pkg::OFS_BG: nxt_q.bg = avs_writedata_i[7:0];
        pmp_pkg::OFS_TC: nxt_q.tc = avs_writedata_i[7:0];
        pmp_pkg::OFS_WMASK: nxt_q.wm = avs_writedata_i[7:0];
        pmp_pkg::OFS_TMASK: nxt_q.tm = avs_writedata_i[7:0];
        default: nxt_q.depth8 = q_ff.depth8;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q_ff <= '0;
      q_ff.depth8 <= pmp_pkg::RST_DEPTH;
      q_ff.align <= pmp_pkg::RST_ALIGN;
      q_ff.nptr <= pmp_pkg::RST_NPTR;
      q_ff.fg <= pmp_pkg::RST_FG;
      q_ff.bg <= pmp_pkg::RST_BG;
      q_ff.tc <= pmp_pkg::RST_TC;
      q_ff.wm <= pmp_pkg::RST_WMASK;
      q_ff.tm <= pmp_pkg::RST_TMASK;
      q_ff.wait_rq <= 1'b1;
    end
    else if (ce_i)
    begin
      q_ff <= nxt_q;
    end
  end

  assign avs_readdata_o = q_ff.rdata;
  assign avs_response_o = q_ff.resp;
  assign avs_waitrequest_o = q_ff.wait_rq;
  assign aligned_o = q_ff.aligned;
  assign expand_o = q_ff.expand;
  assign transp_o = q_ff.transp;
  assign dest_o = q_ff.dest;
  assign pack_o = q_ff.pack;
  assign nptr_o = q_ff.nptr;
  assign op_done_o = q_ff.done;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_bus_answer: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && req && q_ff.wait_rq |=> !avs_waitrequest_o ##1 (avs_waitrequest_o || !$past(ce_i)))
    else $error("waitrequest did not drop for one cycle");

  a_fg_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_acc && avs_address_i == pmp_pkg::OFS_FG |=> q_ff.fg == $past(avs_writedata_i[7:0]))
    else $error("foreground write lost");

  a_nptr_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && !(wr_acc && avs_address_i == pmp_pkg::OFS_NPTR)
    |=> nptr_o == $past(q_ff.nptr) + 2'h1 && op_done_o)
    else $error("nibble pointer did not advance");

  a_align_shift: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && q_ff.align == 2'h2
    |=> aligned_o == {$past(q_ff.prev_src[7:0]), $past(src_word_i[15:8])})
    else $error("alignment shift wrong");

  a_write_mask: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && q_ff.wm == 8'hF8
    |=> dest_o[2:0] == $past(dst_word_i[2:0]) && dest_o[15:11] == $past(result_word_i[15:11]))
    else $error("write mask merge wrong");

  a_test_mask: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && q_ff.depth8 && q_ff.tc == 8'h49 && q_ff.tm == 8'hFC
    |=> transp_o[3] == ($past(al_src[15:10]) == 6'h12))
    else $error("test mask compare wrong");

  a_pack_place: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && q_ff.nptr == 2'h3 |=> pack_o[15:12] == transp_o && pack_o[11:0] == $past(dst_word_i[11:0]))
    else $error("pack result misplaced");

  a_bg_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_acc && avs_address_i == pmp_pkg::OFS_BG) |=> $stable(q_ff.bg))
    else $error("background changed without write");

  a_expand_alt: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && !q_ff.depth8 && sel_nib == 4'hF |=> expand_o == {2{$past(q_ff.fg)}})
    else $error("four bit colour alternation wrong");

  a_bg_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_acc && avs_address_i == pmp_pkg::OFS_BG |=> q_ff.bg == $past(avs_writedata_i[7:0]))
    else $error("background write lost");

  a_tc_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_acc && avs_address_i == pmp_pkg::OFS_TC |=> q_ff.tc == $past(avs_writedata_i[7:0]))
    else $error("transparent colour write lost");

  a_wmask_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_acc && avs_address_i == pmp_pkg::OFS_WMASK |=> q_ff.wm == $past(avs_writedata_i[7:0]))
    else $error("write mask write lost");

  a_tmask_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_acc && avs_address_i == pmp_pkg::OFS_TMASK |=> q_ff.tm == $past(avs_writedata_i[7:0]))
    else $error("test mask write lost");

  a_align_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_acc && avs_address_i == pmp_pkg::OFS_ALIGN |=> q_ff.align == $past(avs_writedata_i[1:0]))
    else $error("alignment write lost");

  a_depth_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_acc && avs_address_i == pmp_pkg::OFS_CTRL |=> q_ff.depth8 == $past(avs_writedata_i[pmp_pkg::DEPTH_BIT]))
    else $error("depth select write lost");

  a_nptr_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && wr_acc && avs_address_i == pmp_pkg::OFS_NPTR |=> nptr_o == $past(avs_writedata_i[1:0]))
    else $error("nibble pointer write lost");

  a_ce_freeze: assert property (@(posedge mclk_i) disable iff (rst_i)
    !ce_i |=> $stable(q_ff))
    else $error("state changed while clock enable low");

  a_keep_unmasked: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i |=> ((dest_o ^ $past(dst_word_i)) & ~{2{$past(q_ff.wm)}}) == 16'h0000)
    else $error("masked destination bit changed");

  a_expand_8bpp: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && q_ff.depth8 && sel_nib[3:2] == 2'h2 |=> expand_o == {$past(q_ff.fg), $past(q_ff.bg)})
    else $error("eight bit expansion wrong");

  a_transp_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && q_ff.depth8 |=> transp_o[1:0] == 2'h0)
    else $error("unused transparency flags set");

  a_read_fg: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && avs_read_i && q_ff.wait_rq && avs_address_i == pmp_pkg::OFS_FG
    |=> avs_readdata_o == {24'h00_0000, $past(q_ff.fg)})
    else $error("foreground read data wrong");

  a_align_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && op_start_i && q_ff.align == 2'h0 |=> aligned_o == $past(src_word_i))
    else $error("zero alignment moved the source");

  a_fg_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_acc && avs_address_i == pmp_pkg::OFS_FG) |=> $stable(q_ff.fg))
    else $error("foreground changed without write");

  a_tc_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_acc && avs_address_i == pmp_pkg::OFS_TC) |=> $stable(q_ff.tc))
    else $error("transparent colour changed without write");

  a_unmapped_err: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && req && q_ff.wait_rq && !mapped |=> avs_response_o == pmp_pkg::RESP_SLVERR)
    else $error("unmapped access not refused");

  c_read: cover property (@(posedge mclk_i) disable iff (rst_i) acc && avs_read_i);
  c_op8: cover property (@(posedge mclk_i) disable iff (rst_i) ce_i && op_start_i && q_ff.depth8);
  c_op_wr: cover property (@(posedge mclk_i) disable iff (rst_i) ce_i && op_start_i && wr_acc);
  c_unmapped: cover property (@(posedge mclk_i) disable iff (rst_i) acc && !mapped);
  c_op4: cover property (@(posedge mclk_i) disable iff (rst_i) ce_i && op_start_i && !q_ff.depth8);

endmodule

// ==== tb/test_pmp_regs.sv ====
// Self-checking testbench for the pixel parameter registers and their datapath.
`timescale 1ns/1ps
module test_pmp_regs;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic [1:0] avs_response_o;
  logic avs_waitrequest_o;
  logic op_start_i = 1'b0;
  logic [15:0] src_word_i = 16'h0, dst_word_i = 16'h0, result_word_i = 16'h0;
  logic [15:0] aligned_o, expand_o, dest_o, pack_o;
  logic [3:0] transp_o;
  logic [1:0] nptr_o;
  logic op_done_o;
  int tests_run = 0;
  int miscompares = 0;
  logic [15:0] prev;
  logic [7:0] msk [1:7] = '{8'h03, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  pmp_regs uut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
    .avs_waitrequest_o(avs_waitrequest_o), .op_start_i(op_start_i), .src_word_i(src_word_i),
    .dst_word_i(dst_word_i), .result_word_i(result_word_i), .aligned_o(aligned_o), .expand_o(expand_o),
    .transp_o(transp_o), .dest_o(dest_o), .pack_o(pack_o), .nptr_o(nptr_o), .op_done_o(op_done_o));

  always #4 mclk_i = ~mclk_i;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
      miscompares++;
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low at a rising edge.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
           output logic [31:0] rd, output logic [1:0] rsp);
    int n;
    @(posedge mclk_i);
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    rsp = avs_response_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0)
    begin
      $display("[FAIL] %0t bus answer timed out", $time);
      miscompares++;
      results();
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic [1:0] rsp;
    bus(1'b1, a, d, 4'hF, rd, rsp);
  endtask

  task rdchk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    logic [31:0] rd;
    logic [1:0] rsp;
    bus(1'b0, a, 32'h0, 4'hF, rd, rsp);
    chk(rd, exp, "read data");
    chk({30'h0, rsp}, {30'h0, rexp}, "response");
  endtask

  // One operation; outputs are judged in the cycle that op_done_o stands.
  task op(input logic [15:0] s, input logic [15:0] d, input logic [15:0] r);
    @(posedge mclk_i);
    op_start_i <= 1'b1;
    src_word_i <= s;
    dst_word_i <= d;
    result_word_i <= r;
    @(posedge mclk_i);
    op_start_i <= 1'b0;
    @(negedge mclk_i);
    chk({31'h0, op_done_o}, 32'h1, "op done");
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_reset();
    rdchk(pmp_pkg::OFS_CTRL, 32'h0, pmp_pkg::RESP_OKAY);
    rdchk(pmp_pkg::OFS_ALIGN, 32'h0, pmp_pkg::RESP_OKAY);
    rdchk(pmp_pkg::OFS_NPTR, 32'h0, pmp_pkg::RESP_OKAY);
    rdchk(pmp_pkg::OFS_FG, 32'hFF, pmp_pkg::RESP_OKAY);
    rdchk(pmp_pkg::OFS_WMASK, 32'hFF, pmp_pkg::RESP_OKAY);
    wr(4'h9, 32'h55);
    rdchk(4'h9, 32'h0, pmp_pkg::RESP_SLVERR);
    $display("test reset values done");
  endtask

  task t_regs();
    logic [31:0] rd;
    logic [1:0] rsp;
    for (int i = 1; i <= 7; i++)
      wr(4'(i), 32'hFFFFFF5A);
    for (int i = 1; i <= 7; i++)
      rdchk(4'(i), {24'h0, 8'h5A & msk[i]}, pmp_pkg::RESP_OKAY);
    bus(1'b1, pmp_pkg::OFS_FG, 32'h0, 4'h0, rd, rsp);
    rdchk(pmp_pkg::OFS_FG, 32'h5A, pmp_pkg::RESP_OKAY);
    $display("test register access done");
  endtask

  task t_align();
    wr(pmp_pkg::OFS_CTRL, 32'h0);
    op(16'h1234, 16'h0, 16'h0);
    prev = 16'h1234;
    for (int a = 0; a < 4; a++)
    begin
      wr(pmp_pkg::OFS_ALIGN, 32'(a));
      op(16'h5678 + 16'(a), 16'h0, 16'h0);
      chk(32'(aligned_o), 32'({prev, 16'h5678 + 16'(a)} >> (4 * a)) & 32'hFFFF, "aligned");
      prev = 16'h5678 + 16'(a);
    end
    wr(pmp_pkg::OFS_ALIGN, 32'h2);
    wr(pmp_pkg::OFS_CTRL, 32'h1);
    op(16'h9ABC, 16'h0, 16'h0);
    chk(32'(aligned_o), {16'h0000, prev[7:0], 8'h9A}, "aligned 8bpp");
    wr(pmp_pkg::OFS_NPTR, 32'h3);
    op(16'h0, 16'h0, 16'h0);
    chk(32'(nptr_o), 32'h0, "pointer wrap");
    rdchk(pmp_pkg::OFS_NPTR, 32'h0, pmp_pkg::RESP_OKAY);
    $display("test alignment and pointer done");
  endtask

  task t_colour();
    wr(pmp_pkg::OFS_ALIGN, 32'h0);
    wr(pmp_pkg::OFS_CTRL, 32'h0);
    wr(pmp_pkg::OFS_FG, 32'hA5);
    wr(pmp_pkg::OFS_BG, 32'h3C);
    wr(pmp_pkg::OFS_TC, 32'h5A);
    wr(pmp_pkg::OFS_TMASK, 32'hFF);
    wr(pmp_pkg::OFS_NPTR, 32'h0);
    op(16'h5A5A, 16'h0, 16'h0);
    chk(32'(expand_o), 32'hACAC, "expand nibble 0");
    chk(32'(transp_o), 32'hF, "transparent 4bpp");
    op(16'hA5F5, 16'h0, 16'h0);
    chk(32'(expand_o), 32'hA5A5, "expand nibble 1");
    chk(32'(transp_o), 32'h0, "opaque 4bpp");
    wr(pmp_pkg::OFS_CTRL, 32'h1);
    op(16'h5A5A, 16'h0, 16'h0);
    chk(32'(expand_o), 32'hA53C, "expand 8bpp");
    $display("test colour expansion done");
  endtask

  task t_masks();
    wr(pmp_pkg::OFS_TC, 32'h49);
    wr(pmp_pkg::OFS_TMASK, 32'hFC);
    wr(pmp_pkg::OFS_WMASK, 32'hF8);
    wr(pmp_pkg::OFS_NPTR, 32'h2);
    op(16'h4B30, 16'h0000, 16'hFFFF);
    chk(32'(transp_o), 32'h8, "test mask");
    chk(32'(dest_o), 32'hF8F8, "write mask set");
    chk(32'(pack_o), 32'h0800, "pack nibble");
    op(16'h4B30, 16'hFFFF, 16'h0000);
    chk(32'(dest_o), 32'h0707, "write mask keep");
    chk(32'(nptr_o), 32'h0, "pointer after two");
    $display("test masks done");
  endtask

  // Clock enable low freezes an operation; a reset in mid-run restores the register values.
  task t_hold();
    @(posedge mclk_i);
    ce_i <= 1'b0;
    op_start_i <= 1'b1;
    @(posedge mclk_i);
    op_start_i <= 1'b0;
    @(negedge mclk_i);
    chk({31'h0, op_done_o}, 32'h0, "frozen op");
    chk(32'(nptr_o), 32'h0, "frozen pointer");
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk(32'(dest_o), 32'h0, "dest after reset");
    rdchk(pmp_pkg::OFS_BG, 32'h0, pmp_pkg::RESP_OKAY);
    rdchk(pmp_pkg::OFS_TMASK, 32'hFF, pmp_pkg::RESP_OKAY);
    $display("test freeze and reset done");
  endtask

  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_align();
    t_colour();
    t_masks();
    t_hold();
    results();
  end
endmodule
